// ===== updown_cnt_pkg.sv
package updown_cnt_pkg;

  // Counter geometry
  localparam int         CNT_W       = 4;
  localparam logic [3:0] CNT_MAX     = 4'hf;
  localparam logic [3:0] CNT_MIN     = 4'h0;
  localparam logic [3:0] CNT_ONE     = 4'h1;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PRESET  = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;

  // Field positions
  localparam int         CTRL_W      = 4;
  localparam int         STAT_CARRY  = 4;

  // Control word, lowest bit is the load request
  typedef struct packed {
    logic up;
    logic trk_en_n;
    logic par_en_n;
    logic load_n;
  } cnt_ctrl_s;

  // Values after reset: idle, counting disabled, direction up
  localparam cnt_ctrl_s  CTRL_RST    = 4'hf;
  localparam logic [3:0] PRESET_RST  = 4'h0;
  localparam logic [3:0] COUNT_RST   = 4'h0;
  localparam logic       CARRY_N_RST = 1'b1;

endpackage : updown_cnt_pkg

// ===== updown_count_core.sv
`timescale 1ns/10ps
module updown_count_core #(
  parameter int W = updown_cnt_pkg::CNT_W
) (
  // Clock and control
  input  wire logic                      core_clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      ce_i,
  // Mode and preset
  input  wire updown_cnt_pkg::cnt_ctrl_s ctrl_i,
  input  wire updown_cnt_pkg::cnt_ctrl_s ctrl_next_i,
  input  wire logic [W-1:0]              preset_i,
  // Counter outputs
  output logic [W-1:0]                   count_o,
  output logic                           carry_n_o
);

  logic [W-1:0] count_next;
  logic         carry_n_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    count_next = count_o;
    if (!ctrl_i.load_n) begin
      count_next = preset_i;
    end else if (!ctrl_i.par_en_n && !ctrl_i.trk_en_n) begin
      if (ctrl_i.up) begin
        count_next = W'(count_o + W'(1));
      end else begin
        count_next = W'(count_o - W'(1));
      end
    end
  end

  // Carry is registered from next-state values so it always equals the
  // terminal decode of the present count and mode, with no extra cycle lag
  always_comb begin
    carry_n_next = 1'b1;
    if (!ctrl_next_i.trk_en_n) begin
      if (ctrl_next_i.up) begin
        carry_n_next = !(&count_next);
      end else begin
        carry_n_next = |count_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count_o <= W'(updown_cnt_pkg::COUNT_RST);
    end else if (ce_i) begin
      count_o <= count_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      carry_n_o <= updown_cnt_pkg::CARRY_N_RST;
    end else if (ce_i) begin
      carry_n_o <= carry_n_next;
    end
  end

endmodule : updown_count_core

// ===== updown_counter_apb.sv
// Behaviour
// - All four count bits change together
// - Load low copies preset on next edge
// - Each bit presettable high or low
// - Count only with both enables low
// - Direction high counts up, low down
// - Trickle enable gates the carry output
// - Carry low at terminal count only
// - Enable changes act only at edges
// - Control changes act at next edge
// - Carry decodes max up, min down
`timescale 1ns/10ps
module updown_counter_apb (
  // Clock and control
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Counter outputs
  output logic [3:0]       count_o,
  output logic             carry_n_o
);

  updown_cnt_pkg::cnt_ctrl_s ctrl_reg;
  updown_cnt_pkg::cnt_ctrl_s ctrl_next;
  logic [3:0]                preset_reg;
  logic [3:0]                preset_next;
  logic                      access_w;
  logic                      done_w;
  logic                      wr_en;
  logic                      hit_ctrl;
  logic                      hit_preset;
  logic                      hit_status;
  logic                      hit_any;
  logic [31:0]               rdata_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases: answer one cycle into the access phase, act on completion
  assign access_w = psel_i && penable_i && !pready_o;
  assign done_w   = psel_i && penable_i && pready_o;
  assign wr_en    = done_w && pwrite_i && pstrb_i[0];
  assign hit_any  = hit_ctrl || hit_preset || hit_status;

  always_comb begin
    hit_ctrl   = 1'b0;
    hit_preset = 1'b0;
    hit_status = 1'b0;
    if (paddr_i == updown_cnt_pkg::OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr_i == updown_cnt_pkg::OFS_PRESET) begin
      hit_preset = 1'b1;
    end else if (paddr_i == updown_cnt_pkg::OFS_STATUS) begin
      hit_status = 1'b1;
    end
  end

  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_mux = 32'(ctrl_reg);
    end else if (hit_preset) begin
      rdata_mux = 32'(preset_reg);
    end else if (hit_status) begin
      rdata_mux = 32'({carry_n_o, count_o});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and preset registers; the count only sees them at a clock edge
  always_comb begin
    ctrl_next   = ctrl_reg;
    preset_next = preset_reg;
    if (wr_en && hit_ctrl) begin
      ctrl_next = updown_cnt_pkg::cnt_ctrl_s'(pwdata_i[updown_cnt_pkg::CTRL_W-1:0]);
    end
    if (wr_en && hit_preset) begin
      preset_next = pwdata_i[3:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_reg <= updown_cnt_pkg::CTRL_RST;
    end else if (ce_i) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      preset_reg <= updown_cnt_pkg::PRESET_RST;
    end else if (ce_i) begin
      preset_reg <= preset_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer; ce low also stalls the handshake, so keep ce high while
  // a transfer is in flight or its completion edge is frozen out
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= access_w;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i && access_w) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_mux;
      pslverr_o <= !hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  updown_count_core #(
    .W (updown_cnt_pkg::CNT_W)
  ) u_core (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .ctrl_i      (ctrl_reg),
    .ctrl_next_i (ctrl_next),
    .preset_i    (preset_reg),
    .count_o     (count_o),
    .carry_n_o   (carry_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_setup;
    psel_i && !penable_i && ce_i;
  endsequence

  sequence s_access;
    psel_i && penable_i && ce_i;
  endsequence

  sequence s_counting;
    ce_i && ctrl_reg.load_n && !ctrl_reg.par_en_n && !ctrl_reg.trk_en_n;
  endsequence

  a_load_copies: assert property (
    ce_i && !ctrl_reg.load_n |=> count_o == $past(preset_reg))
    else $error("load did not copy preset");

  a_count_up: assert property (
    s_counting and ctrl_reg.up |=> count_o == 4'($past(count_o) + updown_cnt_pkg::CNT_ONE))
    else $error("up count step wrong");

  a_count_down: assert property (
    s_counting and !ctrl_reg.up |=> count_o == 4'($past(count_o) - updown_cnt_pkg::CNT_ONE))
    else $error("down count step wrong");

  a_wrap_up: assert property (
    s_counting and ctrl_reg.up && count_o == updown_cnt_pkg::CNT_MAX
      |=> count_o == updown_cnt_pkg::CNT_MIN)
    else $error("up count did not wrap to zero");

  a_hold_idle: assert property (
    ce_i && ctrl_reg.load_n && (ctrl_reg.par_en_n || ctrl_reg.trk_en_n) |=> $stable(count_o))
    else $error("count moved while disabled");

  a_freeze_state: assert property (
    !ce_i |=> $stable(count_o) && $stable(carry_n_o) && $stable(ctrl_reg))
    else $error("state moved with clock enable low");

  a_carry_gate: assert property (
    !carry_n_o |-> !ctrl_reg.trk_en_n)
    else $error("carry active with trickle enable high");

  a_carry_decode: assert property (
    carry_n_o == !(!ctrl_reg.trk_en_n &&
      (ctrl_reg.up ? count_o == updown_cnt_pkg::CNT_MAX : count_o == updown_cnt_pkg::CNT_MIN)))
    else $error("carry does not match terminal count");

  a_ctrl_write: assert property (
    ce_i && wr_en && hit_ctrl
      |=> ctrl_reg == updown_cnt_pkg::cnt_ctrl_s'($past(pwdata_i[3:0])))
    else $error("control write not taken");

  a_apb_ready: assert property (
    s_setup ##1 s_access |=> pready_o ##1 (!pready_o || !ce_i))
    else $error("bus answer not one cycle into access");

  a_apb_error: assert property (
    s_setup ##1 (s_access and !hit_any) |=> pready_o && pslverr_o)
    else $error("unmapped address not flagged");

endmodule : updown_counter_apb

// ===== cascade_stage_model.sv
`timescale 1ns/10ps
module cascade_stage_model (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  // Ripple carry of the lower stage
  input  wire logic       carry_n_i,
  output logic [3:0]      high_cnt_o
);
  // Lower carry is this stage's trickle enable, so no extra gating is needed
  always_ff @(posedge core_clk_i) begin
    if (srst_i) high_cnt_o <= 4'h0;
    else if (!carry_n_i) high_cnt_o <= high_cnt_o + 4'h1;
  end
endmodule : cascade_stage_model

// ===== sync_updown_binary_counter4_tb_top.sv
`timescale 1ns/10ps
module sync_updown_binary_counter4_tb_top;
  logic core_clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'h1, count_o, high_cnt;
  logic pready_o, pslverr_o, carry_n_o, er;
  int miscompares = 0, checked = 0, cycles = 0;
  logic [3:0] hold_modes [3] = '{4'hf, 4'hd, 4'hb};
  ////////////////////////////////////////////////////////////////
  updown_counter_apb u_updown_counter_apb (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .count_o(count_o), .carry_n_o(carry_n_o));
  cascade_stage_model u_cascade_stage_model (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .carry_n_i(carry_n_o), .high_cnt_o(high_cnt));
  always #4 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Hang guard, well above the roughly 140 cycles the tests need
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] d, input logic [3:0] s);
    @(posedge core_clk_i);
    psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= {28'h0, d}; pstrb_i <= s;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    apb(0, updown_cnt_pkg::OFS_CTRL, 4'h0, 4'h1);
    chk("ctrl reset", rd, 32'h0000000f);
    apb(0, updown_cnt_pkg::OFS_PRESET, 4'h0, 4'h1);
    chk("preset reset", rd, 32'h00000000);
    apb(0, updown_cnt_pkg::OFS_STATUS, 4'h0, 4'h1);
    chk("status reset", rd, 32'h00000010);
    $display("test reset done");
    // Load two complementary patterns
    apb(1, updown_cnt_pkg::OFS_PRESET, 4'ha, 4'h1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'he, 4'h1);
    tick(1);
    chk("count load a", count_o, 4'ha);
    apb(1, updown_cnt_pkg::OFS_PRESET, 4'h5, 4'h1);
    tick(2);
    chk("count load 5", count_o, 4'h5);
    $display("test load done");
    // No count unless both enables are low
    foreach (hold_modes[i]) begin
      apb(1, updown_cnt_pkg::OFS_CTRL, hold_modes[i], 4'h1);
      tick(3);
      chk("count held", count_o, 4'h5);
    end
    $display("test hold done");
    apb(1, updown_cnt_pkg::OFS_PRESET, 4'he, 4'h1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'h8, 4'h1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'h9, 4'h1);
    tick(1);
    chk("count up max", count_o, 4'hf);
    chk("carry up max", carry_n_o, 1'b0);
    tick(1);
    chk("count up wrap", count_o, 4'h0);
    chk("carry up wrap", carry_n_o, 1'b1);
    chk("cascade", high_cnt, 4'h1);
    $display("test up done");
    apb(1, updown_cnt_pkg::OFS_PRESET, 4'h1, 4'h1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'h0, 4'h1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'h1, 4'h1);
    tick(1);
    chk("count down min", count_o, 4'h0);
    chk("carry down min", carry_n_o, 1'b0);
    tick(1);
    chk("count down wrap", count_o, 4'hf);
    chk("carry down wrap", carry_n_o, 1'b1);
    $display("test down done");
    apb(1, updown_cnt_pkg::OFS_PRESET, 4'hf, 4'h1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'hc, 4'h1);
    tick(1);
    chk("carry trickle off", carry_n_o, 1'b1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'h0, 4'h1);
    tick(1);
    chk("carry down at max", carry_n_o, 1'b1);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'h8, 4'h1);
    tick(1);
    chk("carry up at max", carry_n_o, 1'b0);
    $display("test carry done");
    // Refused accesses leave state alone
    apb(1, updown_cnt_pkg::OFS_STATUS, 4'h0, 4'h1);
    apb(0, updown_cnt_pkg::OFS_STATUS, 4'h0, 4'h1);
    chk("status ro", rd, 32'h0000000f);
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'hf, 4'h0);
    apb(0, updown_cnt_pkg::OFS_CTRL, 4'h0, 4'h1);
    chk("strobe off", rd, 32'h00000008);
    apb(0, 8'h0c, 4'h0, 4'h1);
    chk("unmapped data", rd, 32'h00000000);
    chk("unmapped err", er, 1'b1);
    $display("test refuse done");
    // Clock enable low must freeze the count and carry mid-count
    apb(1, updown_cnt_pkg::OFS_CTRL, 4'h9, 4'h1);
    ce_i <= 1'b0;
    tick(3);
    chk("count frozen", count_o, 4'hf);
    chk("carry frozen", carry_n_o, 1'b0);
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    tick(1);
    chk("count after freeze", count_o, 4'h0);
    chk("carry after freeze", carry_n_o, 1'b1);
    $display("test freeze done");
    // Reset in mid-run returns everything to idle
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    apb(0, updown_cnt_pkg::OFS_STATUS, 4'h0, 4'h1);
    chk("status after reset", rd, 32'h00000010);
    apb(0, updown_cnt_pkg::OFS_CTRL, 4'h0, 4'h1);
    chk("ctrl after reset", rd, 32'h0000000f);
    $display("test reset again done");
    end_of_test();
  end
endmodule : sync_updown_binary_counter4_tb_top
